// [rtl/lcd_host_pkg.sv]
// Shared constants for the display host port and display RAM addressing block.
`default_nettype none
package lcd_host_pkg;
	// Data path widths.
	localparam int          DATA_W        = 8;
	localparam int          WORD_W        = 9;   // Type bit plus data byte.
	localparam int          FIFO_DEPTH    = 16;
	localparam int          SER_BITS      = 8;
	localparam int          COLS          = 16;
	localparam int          ROWS          = 64;
	localparam int          ROW_W         = 128;
	// Address limits and reset values.
	localparam logic [3:0]  X_LAST        = 4'hF;
	localparam logic [6:0]  Y_LAST        = 7'h3F;
	localparam logic [7:0]  X_SET_LIMIT   = 8'h0F;  // Values above are inhibited.
	localparam logic [7:0]  Y_SET_LIMIT   = 8'h42;  // Values above are inhibited.
	localparam logic [3:0]  RP_RESET      = 4'hC;
	localparam logic [1:0]  INC_RESET     = 2'h0;
	localparam logic [5:0]  START_RESET   = 6'h00;
	// Command byte encodings.
	localparam logic [7:0]  CMD_X_SET     = 8'h80;  // Next command byte is the column.
	localparam logic [7:0]  CMD_Y_SET     = 8'h81;  // Next command byte is the row.
	localparam logic [5:0]  CMD_INC_TOP   = 6'h24;  // 0x90..0x93: {row_step, column_step}.
	localparam logic [1:0]  CMD_START_TOP = 2'h1;   // 0x40..0x7F: start line in bits 5:0.
	localparam logic [3:0]  CMD_RP_TOP    = 4'hC;   // 0xC0..0xCF: read pointer in bits 3:0.
	// Read indexes of the internal registers.
	localparam logic [3:0]  RIDX_X        = 4'h0;
	localparam logic [3:0]  RIDX_Y        = 4'h1;
	localparam logic [3:0]  RIDX_INC      = 4'h2;
	localparam logic [3:0]  RIDX_START    = 4'h3;
	localparam logic [3:0]  RIDX_RP       = 4'hC;
	// Auto increment modes.
	localparam logic [1:0]  INC_NONE      = 2'h0;
	localparam logic [1:0]  INC_COL       = 2'h1;
	localparam logic [1:0]  INC_ROW       = 2'h2;
	localparam logic [1:0]  INC_BOTH      = 2'h3;
	// Pending argument of a two byte command.
	typedef enum logic [1:0] {ARG_NONE, ARG_X, ARG_Y} arg_e;
endpackage : lcd_host_pkg
`default_nettype wire

// [rtl/byte_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	// Filling side.
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Draining side.
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	// Honest full and empty come straight from the fill count.
	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem_q[rp_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Pointer arithmetic wraps at the configured depth; the count stays within zero and the depth.
	always_comb begin
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + AW'(1);
		end
		if (pop) begin
			rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + AW'(1);
		end
		if (push && !pop) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	// Storage is written only on an accepted push.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
		if (push) begin
			mem_q[wp_q] <= i_in_data;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// [rtl/lcd_host_port.sv]
// Host port, display RAM addressing and line counter of a graphic display controller.
// Summary of operation
// - Strap high selects the parallel port, strap low selects the serial inputs.
// - Serial mode is write only; nothing is read back over it.
// - Bus style strap low selects separate active low read and write strobes.
// - Select line high addresses commands, low addresses RAM; strobe gives direction.
// - Chip select inactive clears the serial shift register and bit counter.
// - Serial data sampled on rising serial clock, most significant bit first.
// - Eighth rising serial clock turns the bits into a byte and executes it.
// - In serial mode the select line marks the byte as data or command.
// - Chip select high makes the device ignore every access.
// - Parallel write data is captured on the rising edge of the write strobe.
// - Written bytes wait in a holder and commit the next cycle; a read starting in that cycle is served first.
// - First RAM read after an address set returns stale data.
// - Registers are read by setting a read pointer, then reading.
// - RAM is 128 by 64 bits, column 00..0F, row 00..3F, byte access.
// - Column values 10..FF and row values 43..FF do not set an address.
// - With auto increment on, each RAM read or write advances the address.
// - A six bit start line register selects the row on the first common line.
// - Frame marker high presets the line counter; falling line pulse increments it.
// - Rising line pulse loads the row latch; falling line pulse drives it out.
// - Two bit step select: none, column, row, or both with row carry at 0F.
// - The four bit read pointer resets to C; each register has its index.
`default_nettype none
module lcd_host_port
	import lcd_host_pkg::*;
#(
	parameter int FIFO_WORDS = lcd_host_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rst_n,
	// Straps.
	input  wire logic                        i_port_select_strap,
	input  wire logic                        i_bus_style_strap,
	// Host bus.
	input  wire logic                        i_chip_select_n,
	input  wire logic                        i_reg_or_ram_select,
	input  wire logic                        i_read_strobe_n,
	input  wire logic                        i_write_strobe_n,
	input  wire logic [lcd_host_pkg::DATA_W-1:0] i_data,
	output logic      [lcd_host_pkg::DATA_W-1:0] o_data,
	output logic                             o_data_oe,
	// Serial link.
	input  wire logic                        i_serial_data,
	input  wire logic                        i_serial_clk,
	// Status.
	output logic                             o_write_busy,
	// Display timing and row output.
	input  wire logic                        i_frame_marker,
	input  wire logic                        i_line_latch_pulse,
	output logic      [lcd_host_pkg::ROW_W-1:0]  o_row_data,
	output logic      [5:0]                  o_line_addr
);
	import lcd_host_pkg::*;

	localparam int NSYNC = 18;

	// Address stepping shared by RAM reads and committed RAM writes.
	function automatic logic [10:0] step_addr(input logic [3:0] x, input logic [6:0] y,
			input logic [1:0] mode);
		logic [3:0] nx;
		logic [6:0] ny;
		nx = x;
		ny = y;
		case (mode)
			INC_COL: begin
				nx = x + 4'h1;
			end
			INC_ROW: begin
				ny = (y >= Y_LAST) ? 7'h00 : y + 7'h01;
			end
			INC_BOTH: begin
				nx = x + 4'h1;
				if (x == X_LAST) begin
					ny = (y >= Y_LAST) ? 7'h00 : y + 7'h01;
				end
			end
			default: begin
				nx = x;
			end
		endcase
		return {nx, ny};
	endfunction : step_addr

	// Strobes, select lines and data share one synchroniser, so they stay aligned cycle for cycle.
	// Every pin passes two flip-flops before any logic looks at it.
	logic [NSYNC-1:0] s1_q, s2_q, prev_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			s1_q   <= {6'h3F, 12'h000};
			s2_q   <= {6'h3F, 12'h000};
			prev_q <= {6'h3F, 12'h000};
		end else begin
			s1_q   <= {i_chip_select_n, i_read_strobe_n, i_write_strobe_n, i_reg_or_ram_select,
				i_port_select_strap, i_bus_style_strap, i_serial_data, i_serial_clk,
				i_frame_marker, i_line_latch_pulse, i_data};
			s2_q   <= s1_q;
			prev_q <= s2_q;
		end
	end

	logic       cs_n, rd_n, wr_n, rs, par_mode, style80, sdat, sclk, frame_marker, lp;
	logic [7:0] dbus;
	assign {cs_n, rd_n, wr_n, rs, par_mode, style80, sdat, sclk, frame_marker, lp, dbus} =
		s2_q;

	// Edge events; write, read start and serial clock edges are gated by chip select and the selected port, read end and line pulse edges are not.
	logic par_ok, ser_ok, wr_rise, rd_fall, rd_rise, sclk_rise, lp_rise, lp_fall;
	assign par_ok    = par_mode & ~style80 & ~cs_n;
	assign ser_ok    = ~par_mode & ~cs_n;
	assign wr_rise   = par_ok & wr_n & ~prev_q[15] & rd_n;
	assign rd_fall   = par_ok & ~rd_n & prev_q[16] & wr_n;
	assign rd_rise   = rd_n & ~prev_q[16];
	assign sclk_rise = ser_ok & sclk & ~prev_q[10];
	assign lp_rise   = lp & ~prev_q[8];
	assign lp_fall   = ~lp & prev_q[8];

	// Serial receiver state.
	logic [7:0] shift_q, shift_d;
	logic [2:0] bits_q, bits_d;
	logic       ser_push;
	logic [8:0] ser_word;
	always_comb begin
		shift_d  = shift_q;
		bits_d   = bits_q;
		ser_push = 1'b0;
		ser_word = {rs, shift_q[6:0], sdat};
		if (!ser_ok) begin
			shift_d = 8'h00;
			bits_d  = 3'h0;
		end else if (sclk_rise) begin
			shift_d = {shift_q[6:0], sdat};
			bits_d  = bits_q + 3'h1;
			if (bits_q == 3'(SER_BITS - 1)) begin
				ser_push = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			shift_q <= 8'h00;
			bits_q  <= 3'h0;
		end else begin
			shift_q <= shift_d;
			bits_q  <= bits_d;
		end
	end

	// The FIFO is the write holder: bytes wait here until the commit logic takes them.
	logic       fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [8:0] fifo_in_data, fifo_out_data;
	assign fifo_in_valid = wr_rise | ser_push;
	assign fifo_in_data  = ser_push ? ser_word : {rs, dbus};
	assign o_write_busy  = ~fifo_in_ready;

	byte_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_WORDS)
	) u_holder (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (fifo_in_valid),
		.i_in_data   (fifo_in_data),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (fifo_out_ready)
	);

	// Commit stalls in a read start cycle so the two never fight over the address.
	assign fifo_out_ready = ~rd_fall;

	// Address, control and read path state.
	logic [ROW_W-1:0] ram_q [ROWS];
	logic [3:0]  x_q, x_d;
	logic [6:0]  y_q, y_d;
	logic [1:0]  inc_q, inc_d;
	logic [5:0]  start_q, start_d;
	logic [3:0]  rptr_q, rptr_d;
	arg_e        arg_q, arg_d;
	logic [7:0]  rlatch_q, rlatch_d, dout_q, dout_d;
	logic        oe_q, oe_d;
	logic        ram_we;
	logic [7:0]  ram_wdata;
	logic [7:0]  cur_byte, reg_val, cbyte;
	logic        crs;

	assign cur_byte = (y_q <= Y_LAST) ? ram_q[y_q[5:0]][{x_q, 3'h0} +: 8] : 8'h00;
	assign {crs, cbyte} = fifo_out_data;

	// Indirect register read: the pointer picks which register is returned.
	always_comb begin
		case (rptr_q)
			RIDX_X:     reg_val = {4'h0, x_q};
			RIDX_Y:     reg_val = {1'b0, y_q};
			RIDX_INC:   reg_val = {6'h00, inc_q};
			RIDX_START: reg_val = {2'h0, start_q};
			RIDX_RP:    reg_val = {4'h0, rptr_q};
			default:    reg_val = 8'h00;
		endcase
	end

	always_comb begin
		x_d       = x_q;
		y_d       = y_q;
		inc_d     = inc_q;
		start_d   = start_q;
		rptr_d    = rptr_q;
		arg_d     = arg_q;
		rlatch_d  = rlatch_q;
		dout_d    = dout_q;
		oe_d      = oe_q;
		ram_we    = 1'b0;
		ram_wdata = cbyte;
		// Read cycle: a register read hands out the pointed register; a RAM read hands out the holding latch, then refills it and steps.
		if (rd_fall) begin
			oe_d = 1'b1;
			if (rs) begin
				dout_d = reg_val;
			end else begin
				dout_d   = rlatch_q;
				rlatch_d = cur_byte;
				{x_d, y_d} = step_addr(x_q, y_q, inc_q);
			end
		end else if (rd_rise || cs_n || !par_mode) begin
			oe_d = 1'b0;
		end
		// Commit one held byte per cycle.
		if (fifo_out_valid && fifo_out_ready) begin
			if (!crs) begin
				ram_we = (y_q <= Y_LAST);
				{x_d, y_d} = step_addr(x_q, y_q, inc_q);
			end else begin
				case (arg_q)
					ARG_X: begin
						arg_d = ARG_NONE;
						if (cbyte <= X_SET_LIMIT) begin
							x_d = cbyte[3:0];
						end
					end
					ARG_Y: begin
						arg_d = ARG_NONE;
						if (cbyte <= Y_SET_LIMIT) begin
							y_d = cbyte[6:0];
						end
					end
					default: begin
						if (cbyte == CMD_X_SET) begin
							arg_d = ARG_X;
						end else if (cbyte == CMD_Y_SET) begin
							arg_d = ARG_Y;
						end else if (cbyte[7:2] == CMD_INC_TOP) begin
							inc_d = cbyte[1:0];
						end else if (cbyte[7:6] == CMD_START_TOP) begin
							start_d = cbyte[5:0];
						end else if (cbyte[7:4] == CMD_RP_TOP) begin
							rptr_d = cbyte[3:0];
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			x_q      <= 4'h0;
			y_q      <= 7'h00;
			inc_q    <= INC_RESET;
			start_q  <= START_RESET;
			rptr_q   <= RP_RESET;
			arg_q    <= ARG_NONE;
			rlatch_q <= 8'h00;
			dout_q   <= 8'h00;
			oe_q     <= 1'b0;
		end else begin
			x_q      <= x_d;
			y_q      <= y_d;
			inc_q    <= inc_d;
			start_q  <= start_d;
			rptr_q   <= rptr_d;
			arg_q    <= arg_d;
			rlatch_q <= rlatch_d;
			dout_q   <= dout_d;
			oe_q     <= oe_d;
		end
		if (ram_we) begin
			ram_q[y_q[5:0]][{x_q, 3'h0} +: 8] <= ram_wdata;
		end
	end

	assign o_data    = dout_q;
	assign o_data_oe = oe_q;

	// The line counter is six bits wide, so it wraps from the last row to the first by itself.
	// Display line counter and row latch run from the line pulse edges.
	logic [5:0]       line_q, line_d;
	logic [ROW_W-1:0] rowl_q, rowl_d, rowo_q, rowo_d;
	always_comb begin
		line_d = line_q;
		rowl_d = rowl_q;
		rowo_d = rowo_q;
		if (frame_marker) begin
			line_d = start_q;
		end else if (lp_fall) begin
			line_d = line_q + 6'h01;
		end
		if (lp_rise) begin
			rowl_d = ram_q[line_q];
		end
		if (lp_fall) begin
			rowo_d = rowl_q;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			line_q <= START_RESET;
			rowl_q <= '0;
			rowo_q <= '0;
		end else begin
			line_q <= line_d;
			rowl_q <= rowl_d;
			rowo_q <= rowo_d;
		end
	end

	assign o_row_data  = rowo_q;
	assign o_line_addr = line_q;
endmodule : lcd_host_port
`default_nettype wire

// [verif/lcd_host_port_sva.sv]
// Concurrent checks on the pins of the display host port.
`default_nettype none
module lcd_host_port_sva
	import lcd_host_pkg::*;
(
	// Clock and reset.
	input wire logic                            i_ref_clk,
	input wire logic                            i_rst_n,
	// Straps and host strobes.
	input wire logic                            i_port_select_strap,
	input wire logic                            i_bus_style_strap,
	input wire logic                            i_chip_select_n,
	input wire logic                            i_read_strobe_n,
	input wire logic                            i_write_strobe_n,
	// Read path.
	input wire logic [lcd_host_pkg::DATA_W-1:0] o_data,
	input wire logic                            o_data_oe,
	// Display timing.
	input wire logic                            i_frame_marker,
	input wire logic                            i_line_latch_pulse,
	input wire logic [lcd_host_pkg::ROW_W-1:0]  o_row_data,
	input wire logic [5:0]                      o_line_addr
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	// The bus is only driven after a selected read strobe.
	oe_source_a: assert property (
		$rose(o_data_oe) |-> $past(!i_read_strobe_n && !i_chip_select_n, 2))
		else $error("read drive without a selected read strobe");
	// A selected read in parallel mode is answered within a few cycles.
	read_answer_a: assert property (
		$fell(i_read_strobe_n) && i_write_strobe_n && !i_chip_select_n
		&& i_port_select_strap && !i_bus_style_strap |-> ##[2:6] o_data_oe)
		else $error("read strobe not answered");
	// Serial mode never drives the bus.
	serial_quiet_a: assert property (
		(!i_port_select_strap)[*6] |-> !o_data_oe)
		else $error("bus driven in serial mode");
	// A released chip select leaves the bus alone.
	deselect_quiet_a: assert property (
		i_chip_select_n[*6] |-> !o_data_oe)
		else $error("bus driven while deselected");
	// The other bus style is not served.
	style_quiet_a: assert property (
		i_bus_style_strap[*6] |-> !o_data_oe)
		else $error("bus driven with style strap high");
	// Read data only moves while a read strobe is low.
	data_hold_a: assert property (
		$changed(o_data) |-> $past(!i_read_strobe_n, 3))
		else $error("read data changed outside a read");
	// Without frame marker or line pulse edges the line counter rests.
	line_hold_a: assert property (
		(!i_frame_marker && $stable(i_line_latch_pulse))[*8] |-> $stable(o_line_addr))
		else $error("line counter moved without cause");
	// A falling line pulse advances the counter by exactly one.
	line_step_a: assert property (
		($fell(i_line_latch_pulse) && !i_frame_marker)
		##1 (!i_frame_marker && !i_line_latch_pulse)[*8]
		|-> o_line_addr == $past(o_line_addr, 9) + 6'h01)
		else $error("line counter did not step by one");
	// Row outputs change only after the line pulse has fallen.
	row_load_a: assert property (
		$changed(o_row_data) |-> !$past(i_line_latch_pulse, 2))
		else $error("row output changed outside a falling pulse");
endmodule : lcd_host_port_sva

bind lcd_host_port lcd_host_port_sva sva (.i_ref_clk, .i_rst_n, .i_port_select_strap,
	.i_bus_style_strap, .i_chip_select_n, .i_read_strobe_n, .i_write_strobe_n, .o_data,
	.o_data_oe, .i_frame_marker, .i_line_latch_pulse, .o_row_data, .o_line_addr);
`default_nettype wire

// [verif/serial_master.sv]
// Behavioural serial master that writes bytes over the serial link.
`default_nettype none
module serial_master (
	// Serial link toward the device.
	output logic o_cs_n,
	output logic o_rs,
	output logic o_sdat,
	output logic o_sclk
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle link: clock low and chip released.
	initial begin
		o_cs_n = 1'h1;
		o_rs = 1'h0;
		o_sdat = 1'h0;
		o_sclk = 1'h0;
	end

	// Sends the top nbits of a byte; fewer than eight leaves a broken byte.
	task automatic send(input logic rs, input logic [7:0] d, input int nbits);
		// A small offset keeps every link edge clear of the reference clock edges.
		#0.3;
		o_cs_n = 1'h0;
		o_rs = rs;
		for (int i = 0; i < nbits; i++) begin
			o_sdat = d[7-i];
			#62.5 o_sclk = 1'h1;
			#62.5 o_sclk = 1'h0;
		end
		#62.5 o_cs_n = 1'h1;
		// Released data line shows the inverse so stale levels cannot pass.
		o_sdat = ~o_sdat;
		#249.7;
	endtask : send
endmodule : serial_master
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the display host port.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lcd_host_pkg::*;
	logic             clk, rst_n, ps, style, p_cs_n, p_rs, rd_n, wr_n, fm, lp, busy, oe, qoe;
	logic             s_cs_n, s_rs, sdat, sclk;
	logic [7:0]       din, dout, q, b, s;
	logic [7:0]       mem [16];
	logic [ROW_W-1:0] row;
	logic [5:0]       line;
	int               num_errors, checks;

	serial_master ser (.o_cs_n(s_cs_n), .o_rs(s_rs), .o_sdat(sdat), .o_sclk(sclk));

	lcd_host_port dut (
		.i_ref_clk(clk), .i_rst_n(rst_n),
		.i_port_select_strap(ps), .i_bus_style_strap(style),
		.i_chip_select_n(ps ? p_cs_n : s_cs_n), .i_reg_or_ram_select(ps ? p_rs : s_rs),
		.i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
		.i_data(din), .o_data(dout), .o_data_oe(oe),
		.i_serial_data(sdat), .i_serial_clk(sclk), .o_write_busy(busy),
		.i_frame_marker(fm), .i_line_latch_pulse(lp),
		.o_row_data(row), .o_line_addr(line)
	);

	// Reference clock, 4 ns period.
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	// Cuts a hung run short; all tests finish well inside this span.
	initial begin
		#200us;
		num_errors++;
		end_sim();
	end

	// Counts a comparison and reports a difference at once.
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// One strobe cycle, long enough for the pin synchronisers.
	task automatic bus(input logic r, input logic sel, input logic [7:0] d);
		p_cs_n = 1'h0;
		p_rs = sel;
		din = d;
		rd_n = !r;
		wr_n = r;
		repeat (8) @(negedge clk);
		{qoe, q} = {oe, dout};
		rd_n = 1'h1;
		wr_n = 1'h1;
		repeat (6) @(negedge clk);
		p_cs_n = 1'h1;
		repeat (8) @(negedge clk);
	endtask : bus

	// Indirect register read through the read pointer.
	task automatic rreg(input logic [3:0] idx, input logic [7:0] exp);
		bus(1'h0, 1'h1, {CMD_RP_TOP, idx});
		bus(1'h1, 1'h1, 8'h00);
		cmp(q, exp);
	endtask : rreg

	// Two-byte column and row address commands.
	task automatic setxy(input logic [7:0] x, input logic [7:0] y);
		bus(1'h0, 1'h1, CMD_X_SET);
		bus(1'h0, 1'h1, x);
		bus(1'h0, 1'h1, CMD_Y_SET);
		bus(1'h0, 1'h1, y);
	endtask : setxy

	// Line address expected after n falling line pulses from the start line.
	function automatic logic [7:0] line_after(input logic [7:0] start, input int n);
		return {2'h0, 6'(start[5:0] + 6'(n))};
	endfunction : line_after

	// Prints the verdict and ends the run.
	task automatic end_sim();
		if (num_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// Main test sequence.
	initial begin
		{rst_n, style, p_rs, din, fm, lp} = '0;
		{ps, p_cs_n, rd_n, wr_n} = 4'hF;
		void'($urandom(32'h76DDCB8A));
		repeat (10) @(negedge clk);
		rst_n = 1'h1;
		repeat (4) @(negedge clk);
		bus(1'h1, 1'h1, 8'h00);
		cmp(q, {4'h0, RP_RESET});
		cmp({7'h00, qoe}, 8'h01);
		cmp({7'h00, busy}, 8'h00);
		// Column stepping over a full row, then read back after a dummy read.
		bus(1'h0, 1'h1, {CMD_INC_TOP, INC_COL});
		setxy(8'h00, 8'h05);
		for (int i = 0; i < COLS; i++) begin
			mem[i] = 8'($urandom);
			bus(1'h0, 1'h0, mem[i]);
		end
		rreg(RIDX_X, 8'h00);
		setxy(8'h00, 8'h05);
		bus(1'h1, 1'h0, 8'h00);
		for (int i = 0; i < COLS; i++) begin
			bus(1'h1, 1'h0, 8'h00);
			cmp(q, mem[i]);
		end
		// Combined stepping carries into the row at the last column.
		bus(1'h0, 1'h1, {CMD_INC_TOP, INC_BOTH});
		setxy(8'h0F, 8'h07);
		bus(1'h0, 1'h0, 8'hA5);
		rreg(RIDX_X, 8'h00);
		rreg(RIDX_Y, 8'h08);
		// Row stepping only, then no stepping at all.
		bus(1'h0, 1'h1, {CMD_INC_TOP, INC_ROW});
		rreg(RIDX_INC, {6'h00, INC_ROW});
		bus(1'h0, 1'h0, 8'h5A);
		rreg(RIDX_Y, 8'h09);
		rreg(RIDX_X, 8'h00);
		bus(1'h0, 1'h1, {CMD_INC_TOP, INC_NONE});
		bus(1'h0, 1'h0, 8'h3C);
		rreg(RIDX_Y, 8'h09);
		// Inhibited address values leave the address alone.
		bus(1'h0, 1'h1, CMD_X_SET);
		bus(1'h0, 1'h1, 8'h05);
		for (int i = 0; i < 2; i++) begin
			b = i[0] ? 8'hFF : 8'h10;
			bus(1'h0, 1'h1, CMD_X_SET);
			bus(1'h0, 1'h1, b);
			rreg(RIDX_X, 8'h05);
			bus(1'h0, 1'h1, CMD_Y_SET);
			bus(1'h0, 1'h1, b | 8'h43);
			rreg(RIDX_Y, 8'h09);
		end
		// Start line at 3C..3F so the counter reaches the top and wraps unless it starts at 3C; next row holds data.
		s = {2'h0, 6'($urandom) | 6'h3C};
		setxy(8'h00, {2'h0, 6'(s[5:0] + 6'h01)});
		bus(1'h0, 1'h0, 8'hFF);
		bus(1'h0, 1'h1, {CMD_START_TOP, s[5:0]});
		rreg(RIDX_START, s);
		fm = 1'h1;
		repeat (10) @(negedge clk);
		fm = 1'h0;
		repeat (10) @(negedge clk);
		cmp({2'h0, line}, s);
		for (int i = 1; i < 4; i++) begin
			lp = 1'h1;
			repeat (10) @(negedge clk);
			lp = 1'h0;
			repeat (10) @(negedge clk);
			cmp({2'h0, line}, line_after(s, i));
			if (i == 2) begin
				cmp(row[7:0], 8'hFF);
			end
		end
		// Wrong bus style: the read must not be served.
		style = 1'h1;
		repeat (6) @(negedge clk);
		bus(1'h1, 1'h1, 8'h00);
		cmp({7'h00, qoe}, 8'h00);
		style = 1'h0;
		// Serial writes after a broken byte, read back in parallel mode.
		ps = 1'h0;
		repeat (6) @(negedge clk);
		b = 8'($urandom);
		ser.send(1'h1, 8'hFF, 3);
		ser.send(1'h1, CMD_X_SET, 8);
		ser.send(1'h1, 8'h03, 8);
		ser.send(1'h1, CMD_Y_SET, 8);
		ser.send(1'h1, 8'h09, 8);
		ser.send(1'h0, b, 8);
		@(negedge clk);
		ps = 1'h1;
		repeat (6) @(negedge clk);
		setxy(8'h03, 8'h09);
		bus(1'h1, 1'h0, 8'h00);
		bus(1'h1, 1'h0, 8'h00);
		cmp(q, b);
		end_sim();
	end
endmodule : tb
`default_nettype wire
